// File: rtl/otp_jtag_debug_port.sv
// Tile test/debug port: chained boundary-scan and chip TAP, OTP store, boot loader, debug pin.
// Assumes clk_sys at 200 MHz; JTAG pins and pll lock arrive from outside this clock domain.
// Operation
// RQ1: OTP is 8 KB, four sectors of 512 rows, 32 bits each.
// RQ2: Security register loads from OTP at power up before operation.
// RQ3: Remaining programmed OTP is copied to SRAM and executed first.
// RQ4: OTP programming address comes through 16-bit port 0x100200.
// RQ5: OTP programming write data comes through 32-bit port 0x200100.
// RQ6: OTP programming control goes through 16-bit port 0x100300.
// RQ7: After reset the chain holds a boundary-scan TAP then chip TAP.
// RQ8: Boundary-scan TAP follows 1149.1 and scans the I/O pins.
// RQ9: Chip TAP reaches tile, switch and OTP for loading and debug.
// RQ10: Test reset low holds JTAG in reset; host holds it 100 ns.
// RQ11: Debug pin as output floats until breakpoint, then driven low.
// RQ12: Debug pin as input, driven low, puts tile in debug mode.
// RQ13: JTAG_IDENTIFICATION_VALUE selects 32-bit version, part, maker fields, bit 0 one.
// RQ14: USERCODE selects user identity, unused, silicon revision fields.
// RQ15: User identity mirrors security bits 22..31; zero when unprogrammed.
// RQ16: System reset is active low and asserts asynchronously.
// RQ17: After reset release, wait for PLL lock, then boot.
// RQ18: Host holds system reset low at least 100 ns at power up; the bench releases rst_n_pin after 23.5 ns.
// RQ19: Security bit 13 blocks JTAG read and write of this OTP.
// RQ20: Security bit 0 disables the JTAG interface.
// RQ21: Security bit 14 disables the debug pin.
// RQ22: Chip TAP is a sixteen-state controller shifting LSB first.
`include "otp_jtag_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module otp_jtag_debug_port
	import otp_jtag_pkg::*;
#(
	parameter int BSR_BITS = 8,
	parameter logic [3:0] VERSION = 4'h0,
	parameter logic [15:0] PART_NUMBER = 16'h1234, // Arbitrary value
	parameter logic [10:0] MAKER_ID = 11'h055, // Arbitrary value
	parameter logic [11:0] SI_REVISION = 12'h001 // Arbitrary value
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic rst_n_pin,
	input wire logic pll_lock,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdo_oe_n,
	input wire logic [BSR_BITS-1:0] io_pins_in,
	output logic [BSR_BITS-1:0] io_pins_out,
	output logic extest_active,
	input wire logic debug_pin_in,
	output logic debug_pin_out,
	output logic debug_pin_oe_n,
	input wire logic debug_pin_is_output,
	input wire logic breakpoint_hit,
	output logic debug_mode,
	output logic [`OTP_ADDR_BITS-1:0] sram_addr,
	output logic [`OTP_ROW_BITS-1:0] sram_wdata,
	output logic sram_we,
	output logic cpu_start,
	output logic [`OTP_ROW_BITS-1:0] security_q
);
	localparam int DEPTH = `OTP_SECTORS * `OTP_ROWS_PER_SECTOR;
	logic [`OTP_ROW_BITS-1:0] otp_mem [DEPTH]; // [RQ1]
	logic tck_s, tms_s, tdi_s, trst_s, rst_s, lock_s, dbg_s;
	logic rst_async_q1, rst_async_q2;
	logic jtag_rst;
	tap_if bs_tap();
	tap_if ch_tap();

	// Asynchronous assertion, synchronous release of system reset [RQ16]
	always_ff @(posedge clk_sys or negedge rst_n_pin) begin
		if (!rst_n_pin) begin
			rst_async_q1 <= 1'b0;
			rst_async_q2 <= 1'b0;
		end else begin
			rst_async_q1 <= 1'b1;
			rst_async_q2 <= rst_async_q1;
		end
	end
	assign rst_s = rst_b && rst_async_q2;

	pin_sync #(.INIT(1'b0)) u_tck (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce), .pin(tck),
		.level(tck_s));
	pin_sync #(.INIT(1'b1)) u_tms (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce), .pin(tms),
		.level(tms_s));
	pin_sync #(.INIT(1'b0)) u_tdi (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce), .pin(tdi),
		.level(tdi_s));
	pin_sync #(.INIT(1'b0)) u_trst (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce), .pin(trst_n),
		.level(trst_s));
	pin_sync #(.INIT(1'b0)) u_lock (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce),
		.pin(pll_lock), .level(lock_s));
	pin_sync #(.INIT(1'b1)) u_dbg (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce),
		.pin(debug_pin_in), .level(dbg_s));

	// Test reset low, or the disable bit, keeps both TAPs in reset [RQ10] [RQ20]
	assign jtag_rst = !trst_s || security_q[`SEC_JTAG_OFF];
	assign bs_tap.tms = tms_s;
	assign ch_tap.tms = tms_s;
	tap_fsm u_bs_fsm (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce), .jtag_rst(jtag_rst),
		.tck_lvl(tck_s), .tap(bs_tap.ctrl));
	tap_fsm u_ch_fsm (.clk_sys(clk_sys), .rst_b(rst_s), .ce(ce), .jtag_rst(jtag_rst),
		.tck_lvl(tck_s), .tap(ch_tap.ctrl));

	// Boot sequencer
	boot_state_t boot_q;
	logic [`OTP_ADDR_BITS-1:0] boot_row_q;
	logic otp_busy;
	assign otp_busy = boot_q != BOOT_RUN;
	always_ff @(posedge clk_sys) begin
		if (!rst_s) begin
			boot_q <= BOOT_PLL;
			boot_row_q <= `BOOT_FIRST_ROW;
			security_q <= '0;
			sram_we <= 1'b0;
			sram_addr <= '0;
			sram_wdata <= '0;
			cpu_start <= 1'b0;
		end else if (ce) begin
			sram_we <= 1'b0;
			unique case (boot_q)
				BOOT_PLL: if (lock_s) boot_q <= BOOT_SEC; // [RQ17]
				BOOT_SEC: begin
					security_q <= otp_mem[`SEC_ROW]; // [RQ2]
					boot_q <= BOOT_COPY;
				end
				BOOT_COPY: begin
					sram_we <= 1'b1; // [RQ3]
					sram_addr <= boot_row_q - `BOOT_FIRST_ROW;
					sram_wdata <= otp_mem[boot_row_q];
					boot_row_q <= boot_row_q + 1'b1;
					if (boot_row_q == `OTP_ADDR_BITS'(DEPTH - 1)) boot_q <= BOOT_RUN;
				end
				BOOT_RUN: cpu_start <= 1'b1; // [RQ3]
			endcase
		end
	end

	// Boundary-scan TAP, last in chain, drives TDO
	logic [`IR_BITS-1:0] bs_ir_q, bs_irs_q;
	logic [BSR_BITS-1:0] bsr_q;
	logic [31:0] bs_dr_q;
	logic bs_tdo;
	logic ch_tdo_w;
	logic [31:0] jtag_identification_value;
	assign jtag_identification_value = {VERSION, PART_NUMBER, MAKER_ID, 1'b1}; // [RQ13]
	always_ff @(posedge clk_sys) begin
		if (!rst_s || (ce && bs_tap.state == TEST_LOGIC_RESET)) begin
			bs_ir_q <= `IR_JTAG_IDENTIFICATION_VALUE;
			bs_irs_q <= '0;
			bs_dr_q <= '0;
			io_pins_out <= '0;
			extest_active <= 1'b0;
		end else if (bs_tap.tck_rise) begin
			unique case (bs_tap.state)
				CAPTURE_IR: bs_irs_q <= `IR_BITS'(1);
				SHIFT_IR: bs_irs_q <= {ch_tdo_w, bs_irs_q[`IR_BITS-1:1]}; // [RQ22]
				UPDATE_IR: begin
					bs_ir_q <= bs_irs_q;
					extest_active <= bs_irs_q == `IR_EXTEST; // [RQ8]
				end
				CAPTURE_DR: begin
					if (bs_ir_q == `IR_JTAG_IDENTIFICATION_VALUE) bs_dr_q <= jtag_identification_value;
					else if (bs_ir_q == `IR_EXTEST || bs_ir_q == `IR_SAMPLE)
						bs_dr_q <= 32'(io_pins_in); // [RQ8]
					else bs_dr_q <= '0;
				end
				SHIFT_DR: bs_dr_q <= {ch_tdo_w, bs_dr_q[31:1]};
				UPDATE_DR: if (bs_ir_q == `IR_EXTEST) io_pins_out <= bs_dr_q[BSR_BITS-1:0];
				default: ;
			endcase
		end
	end
	assign bsr_q = bs_dr_q[BSR_BITS-1:0];

	// Chip TAP sits between TDI and the boundary TAP [RQ7]
	logic [`IR_BITS-1:0] ch_ir_q, ch_irs_q;
	logic [31:0] ch_dr_q;
	logic [15:0] otp_addr_q; // [RQ4]
	logic [31:0] otp_data_q; // [RQ5]
	logic [15:0] otp_ctrl_q; // [RQ6]
	logic otp_blocked;
	logic [31:0] usercode;
	logic [1:0] sect;
	assign usercode = {security_q[`SEC_USER_HI:`SEC_USER_LO], 10'h000, SI_REVISION}; // [RQ14] [RQ15]
	assign otp_blocked = security_q[`SEC_JTAG_OTP_OFF]; // [RQ19]
	assign sect = otp_addr_q[`OTP_ADDR_BITS-1:`OTP_ADDR_BITS-2];
	always_ff @(posedge clk_sys) begin
		if (!rst_s || (ce && ch_tap.state == TEST_LOGIC_RESET)) begin
			ch_ir_q <= `IR_BYPASS;
			ch_irs_q <= '0;
			ch_dr_q <= '0;
			otp_addr_q <= '0;
			otp_data_q <= '0;
			otp_ctrl_q <= '0;
		end else if (ch_tap.tck_rise) begin
			otp_ctrl_q <= '0;
			unique case (ch_tap.state)
				CAPTURE_IR: ch_irs_q <= `IR_BITS'(1);
				SHIFT_IR: ch_irs_q <= {tdi_s, ch_irs_q[`IR_BITS-1:1]}; // [RQ22]
				UPDATE_IR: ch_ir_q <= ch_irs_q;
				CAPTURE_DR: begin // [RQ9]
					unique case (ch_ir_q)
						`IR_USERCODE: ch_dr_q <= usercode;
						`IR_OTP_ADDR: ch_dr_q <= 32'(otp_addr_q);
						`IR_OTP_DATA: ch_dr_q <= otp_data_q;
						default: ch_dr_q <= '0;
					endcase
				end
				SHIFT_DR: ch_dr_q <= {tdi_s, ch_dr_q[31:1]}; // [RQ22]
				UPDATE_DR: begin
					unique case (ch_ir_q)
						`IR_OTP_ADDR: otp_addr_q <= ch_dr_q[15:0];
						`IR_OTP_DATA: otp_data_q <= ch_dr_q;
						`IR_OTP_CTRL: otp_ctrl_q <= ch_dr_q[15:0];
						default: ;
					endcase
				end
				default: ;
			endcase
			if (otp_ctrl_q[`CTRL_READ] && !otp_blocked) // [RQ19]
				otp_data_q <= otp_mem[otp_addr_q[`OTP_ADDR_BITS-1:0]];
		end
	end
	assign ch_tdo_w = (ch_tap.state == SHIFT_IR) ? ch_irs_q[0] :
		(ch_ir_q == `IR_BYPASS) ? ch_dr_q[31] : ch_dr_q[0];

	// OTP programming: bits only ever go from zero to one, honouring locks
	always_ff @(posedge clk_sys) begin
		if (ce && otp_ctrl_q[`CTRL_PROG] && !otp_blocked && !otp_busy &&
			!security_q[`SEC_MASTER_LOCK] && !security_q[`SEC_LOCK_LO + sect]) begin
			otp_mem[otp_addr_q[`OTP_ADDR_BITS-1:0]] <=
				otp_mem[otp_addr_q[`OTP_ADDR_BITS-1:0]] | otp_data_q;
		end
	end

	// TDO changes on the falling edge, driven only in shift states
	// Bypass acts as a one-bit stage: the bit shifted in last leaves next [RQ8]
	assign bs_tdo = (bs_tap.state == SHIFT_IR) ? bs_irs_q[0] :
		(bs_ir_q == `IR_BYPASS) ? bs_dr_q[31] : bs_dr_q[0];
	always_ff @(posedge clk_sys) begin
		if (!rst_s || (ce && jtag_rst)) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (bs_tap.tck_fall) begin
			tdo <= bs_tdo;
			tdo_oe_n <= !(bs_tap.state == SHIFT_DR || bs_tap.state == SHIFT_IR);
		end
	end

	// Debug pin; the disable bit wins over both directions [RQ21]
	always_ff @(posedge clk_sys) begin
		if (!rst_s) begin
			debug_pin_out <= 1'b0;
			debug_pin_oe_n <= 1'b1;
			debug_mode <= 1'b0;
		end else if (ce) begin
			debug_pin_out <= 1'b0;
			debug_pin_oe_n <= !(debug_pin_is_output && breakpoint_hit &&
				!security_q[`SEC_DEBUG_PIN_OFF]); // [RQ11]
			if (!debug_pin_is_output && !dbg_s && !security_q[`SEC_DEBUG_PIN_OFF])
				debug_mode <= 1'b1; // [RQ12]
			else if (!breakpoint_hit && dbg_s)
				debug_mode <= 1'b0;
		end
	end
endmodule : otp_jtag_debug_port
`default_nettype wire

// File: rtl/otp_jtag_regs.svh
// Constants for the tile debug and OTP access port.
// Assumes inclusion by bare name from rtl/.
`ifndef OTP_JTAG_REGS_SVH
`define OTP_JTAG_REGS_SVH
`define OTP_SECTORS 4
`define OTP_ROWS_PER_SECTOR 512
`define OTP_ROW_BITS 32
`define OTP_ADDR_BITS 11
`define RES_OTP_ADDR 24'h100200
`define RES_OTP_DATA 24'h200100
`define RES_OTP_CTRL 24'h100300
`define SEC_JTAG_OFF 0
`define SEC_LINK_OFF 1
`define SEC_LOCK_LO 8
`define SEC_MASTER_LOCK 12
`define SEC_JTAG_OTP_OFF 13
`define SEC_DEBUG_PIN_OFF 14
`define SEC_USER_LO 22
`define SEC_USER_HI 31
`define SEC_ROW 11'h000
`define BOOT_FIRST_ROW 11'h001
`define IR_BITS 4
`define IR_JTAG_IDENTIFICATION_VALUE 4'h1
`define IR_USERCODE 4'h2
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h3
`define IR_OTP_ADDR 4'h4
`define IR_OTP_DATA 4'h5
`define IR_OTP_CTRL 4'h6
`define IR_BYPASS 4'hf
`define CTRL_READ 0
`define CTRL_PROG 1
`define TRST_MIN_NS 100
`define CLK_PERIOD_NS 5
`define TRST_MIN_CYC ((`TRST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: rtl/otp_jtag_pkg.sv
// Types shared by the tile debug port modules.
// Assumes no surroundings.
package otp_jtag_pkg;
	typedef enum logic [3:0] {
		TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
		PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR,
		EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
	} tap_state_t;
	typedef enum logic [2:0] {BOOT_PLL, BOOT_SEC, BOOT_COPY, BOOT_RUN} boot_state_t;
endpackage : otp_jtag_pkg

// File: rtl/tap_if.sv
// Bundle from the TAP controller to the port's data logic.
// Assumes one clock domain, clk_sys.
`timescale 1ns/100ps
`default_nettype none
interface tap_if;
	import otp_jtag_pkg::*;
	logic tck_rise;
	logic tck_fall;
	logic tms;
	tap_state_t state;
	modport ctrl (output tck_rise, output tck_fall, output state, input tms);
	modport user (input tck_rise, input tck_fall, input state, output tms);
endinterface : tap_if
`default_nettype wire

// File: rtl/pin_sync.sv
// Three-stage synchroniser for a pin; change accepted when stages two and three agree.
// Assumes clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(parameter logic INIT = 1'b0) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic pin,
	output logic level
);
	logic [2:0] sh_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sh_q <= {3{INIT}};
		end else if (ce) begin
			sh_q <= {sh_q[1:0], pin};
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			level <= INIT;
		end else if (ce && sh_q[1] == sh_q[2]) begin
			level <= sh_q[2];
		end
	end
endmodule : pin_sync
`default_nettype wire

// File: rtl/tap_fsm.sv
// Sixteen-state TAP controller stepped on sampled test clock edges.
// Assumes tck and tms already synchronised; jtag_rst is synchronous.
`timescale 1ns/100ps
`default_nettype none
module tap_fsm
	import otp_jtag_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic jtag_rst,
	input wire logic tck_lvl,
	tap_if.ctrl tap
);
	logic tck_q;
	tap_state_t st_q;
	tap_state_t st_d;
	assign tap.tck_rise = ce && tck_lvl && !tck_q;
	assign tap.tck_fall = ce && !tck_lvl && tck_q;
	assign tap.state = st_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			tck_q <= 1'b0;
		end else if (ce) begin
			tck_q <= tck_lvl;
		end
	end
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			TEST_LOGIC_RESET: st_d = tap.tms ? TEST_LOGIC_RESET : RUN_IDLE;
			RUN_IDLE: st_d = tap.tms ? SELECT_DR : RUN_IDLE;
			SELECT_DR: st_d = tap.tms ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR: st_d = tap.tms ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: st_d = tap.tms ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: st_d = tap.tms ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR: st_d = tap.tms ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: st_d = tap.tms ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR: st_d = tap.tms ? SELECT_DR : RUN_IDLE;
			SELECT_IR: st_d = tap.tms ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR: st_d = tap.tms ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: st_d = tap.tms ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: st_d = tap.tms ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR: st_d = tap.tms ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: st_d = tap.tms ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR: st_d = tap.tms ? SELECT_DR : RUN_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b || (ce && jtag_rst)) begin
			st_q <= TEST_LOGIC_RESET;
		end else if (tap.tck_rise) begin
			st_q <= st_d; // [RQ22]
		end
	end
endmodule : tap_fsm
`default_nettype wire

// File: test/otp_jtag_debug_port_sva.sv
// Concurrent checks on the tile debug port pins.
// Assumes binding to otp_jtag_debug_port; sees only its ports.
`include "otp_jtag_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module otp_jtag_debug_port_sva (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic rst_n_pin,
	input wire logic pll_lock,
	input wire logic trst_n,
	input wire logic tdo_oe_n,
	input wire logic debug_pin_in,
	input wire logic debug_pin_out,
	input wire logic debug_pin_oe_n,
	input wire logic debug_pin_is_output,
	input wire logic breakpoint_hit,
	input wire logic debug_mode,
	input wire logic [`OTP_ADDR_BITS-1:0] sram_addr,
	input wire logic sram_we,
	input wire logic cpu_start,
	input wire logic [`OTP_ROW_BITS-1:0] security_q
);
	logic [11:0] lock_cnt_q;
	// Saturates so a long run never wraps into a false early start
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !rst_n_pin || !pll_lock) begin
			lock_cnt_q <= 12'h000;
		end else if (lock_cnt_q != 12'hfff) begin
			lock_cnt_q <= lock_cnt_q + 12'h001;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b || !rst_n_pin);
	a_reset_clears: assert property (disable iff (!rst_b) !rst_n_pin ##1 !rst_n_pin |-> !cpu_start && !sram_we && tdo_oe_n)
		else $error("system reset did not clear outputs");
	a_boot_after_lock: assert property ($rose(cpu_start) |-> lock_cnt_q >= 12'd2047)
		else $error("processor started too soon after lock");
	a_copy_step: assert property (sram_we ##1 sram_we |-> sram_addr == $past(sram_addr) + 11'h001)
		else $error("copy address not sequential");
	a_copy_first: assert property (sram_we |-> !cpu_start)
		else $error("processor running during copy");
	a_sec_frozen: assert property (cpu_start && $past(cpu_start) |-> $stable(security_q))
		else $error("security value changed after start");
	a_trst_holds: assert property (!trst_n [*6] |-> tdo_oe_n)
		else $error("test data driven while test reset low");
	a_jtag_off: assert property (security_q[0] && $past(security_q[0]) |-> tdo_oe_n)
		else $error("test data driven while scan port disabled");
	a_dbg_float: assert property (!breakpoint_hit [*3] |-> debug_pin_oe_n)
		else $error("debug pin driven without breakpoint");
	a_dbg_drive: assert property ((debug_pin_is_output && breakpoint_hit && !security_q[14]) [*3]
		|-> !debug_pin_oe_n && !debug_pin_out)
		else $error("debug pin not driven low at breakpoint");
	a_dbg_off: assert property (security_q[14] [*2] |-> debug_pin_oe_n)
		else $error("debug pin driven while disabled");
	a_dbg_enter: assert property ((!debug_pin_is_output && !debug_pin_in && !security_q[14]) [*6]
		|-> debug_mode)
		else $error("low debug pin did not enter debug mode");
	cover property ($rose(cpu_start));
	cover property (!tdo_oe_n);
	cover property (!debug_pin_oe_n);
	cover property ($rose(debug_mode));
endmodule : otp_jtag_debug_port_sva
bind otp_jtag_debug_port otp_jtag_debug_port_sva u_sva (.clk_sys, .rst_b, .rst_n_pin, .pll_lock,
	.trst_n, .tdo_oe_n, .debug_pin_in, .debug_pin_out, .debug_pin_oe_n, .debug_pin_is_output,
	.breakpoint_hit, .debug_mode, .sram_addr, .sram_we, .cpu_start, .security_q);
`default_nettype wire

// File: test/jtag_host.sv
// Behavioural scan debugger driving the test pins.
// Assumes tdo settles within 40 ns of a falling tck; tck rests low between frames.
`timescale 1ns/100ps
`default_nettype none
module jtag_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo,
	input wire logic tdo_oe_n
);
	logic drove;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b0;
		drove = 1'b0;
	end
	// One 80 ns test clock; tdo is taken before the rise, where the TAP shifts
	task step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#40;
		o = tdo;
		drove = drove | !tdo_oe_n;
		tck = 1'b1;
		#40;
		tck = 1'b0;
	endtask : step
	task reset_tap();
		logic o;
		trst_n = 1'b0;
		#120;
		trst_n = 1'b1;
		#40;
		step(1'b0, ~tdi, o);
	endtask : reset_tap
	// From Run-Idle: scan n bits through IR or DR, back to Run-Idle
	task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, ~tdi, o);
		if (ir) begin
			step(1'b1, ~tdi, o);
		end
		step(1'b0, ~tdi, o);
		step(1'b0, ~tdi, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, (i < 32) ? din[i] : 1'b0, o);
			dout = {o, dout[31:1]};
		end
		step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	endtask : scan
endmodule : jtag_host
`default_nettype wire

// File: test/otp_jtag_debug_port_tb.sv
// Self-checking bench: boot copy, scan registers, debug pin, security bits.
// Assumes the OTP array can be preloaded through dut.otp_mem.
`include "otp_jtag_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module otp_jtag_debug_port_tb;
	localparam logic [3:0] VER = 4'h3; // Arbitrary value
	localparam logic [15:0] PART = 16'h0abc; // Arbitrary value
	localparam logic [10:0] MAKER = 11'h123; // Arbitrary value
	localparam logic [11:0] REV = 12'h045; // Arbitrary value
	localparam logic [31:0] ROW0 = 32'ha940_0000;
	logic clk_sys, rst_b, rst_n_pin, pll_lock, tck, tms, tdi, trst_n, tdo, tdo_oe_n;
	logic debug_pin_in, debug_pin_out, debug_pin_oe_n, debug_pin_is_output, breakpoint_hit;
	logic debug_mode, sram_we, cpu_start;
	logic [`OTP_ADDR_BITS-1:0] sram_addr;
	logic [31:0] sram_wdata, security_q, word;
	int n_fail, n_compared, n_wr;
	otp_jtag_debug_port #(.VERSION(VER), .PART_NUMBER(PART), .MAKER_ID(MAKER),
		.SI_REVISION(REV)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1),
		.rst_n_pin(rst_n_pin), .pll_lock(pll_lock), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .io_pins_in(8'ha5), .io_pins_out(),
		.extest_active(), .debug_pin_in(debug_pin_in), .debug_pin_out(debug_pin_out),
		.debug_pin_oe_n(debug_pin_oe_n), .debug_pin_is_output(debug_pin_is_output),
		.breakpoint_hit(breakpoint_hit), .debug_mode(debug_mode), .sram_addr(sram_addr),
		.sram_wdata(sram_wdata), .sram_we(sram_we), .cpu_start(cpu_start),
		.security_q(security_q));
	jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
		.tdo_oe_n(tdo_oe_n));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] row_val(input logic [11:0] r);
		return 32'hc3c3_0000 | {20'h00000, r};
	endfunction : row_val
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task final_report();
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task wait_start();
		for (int i = 0; i < 3000 && cpu_start !== 1'b1; i++) begin
			tick(1);
		end
		check("cpu_start", 32'(cpu_start), 32'h1);
	endtask : wait_start
	// Each copied word must be the OTP row one above its SRAM address
	always @(negedge clk_sys) begin
		if (sram_we === 1'b1) begin
			check("sram_wdata", sram_wdata, row_val({1'b0, sram_addr} + 12'h001));
			n_wr++;
		end
	end
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
	initial begin
		rst_b = 1'b0;
		rst_n_pin = 1'b0;
		pll_lock = 1'b0;
		debug_pin_in = 1'b1;
		debug_pin_is_output = 1'b1;
		breakpoint_hit = 1'b0;
		n_fail = 0;
		n_compared = 0;
		n_wr = 0;
		for (int r = 1; r < 2048; r++) begin
			dut.otp_mem[r] = row_val(r[11:0]);
		end
		dut.otp_mem[0] = ROW0;
		tick(5);
		rst_b = 1'b1;
		rst_n_pin = 1'b1;
		tick(20);
		check("cpu_start", 32'(cpu_start), 32'h0);
		check("copies", 32'(n_wr), 32'h0);
		pll_lock = 1'b1;
		wait_start();
		check("copies", 32'(n_wr), 32'd2047);
		check("security", security_q, ROW0);
		host.reset_tap();
		host.scan(1'b0, 32, 32'h0, word);
		check("jtag_identification_value", word, {VER, PART, MAKER, 1'b1});
		host.scan(1'b1, 8, 32'hf3, word);
		host.scan(1'b0, 32, 32'h0, word);
		check("sample", word, 32'h0000_00a5);
		host.scan(1'b1, 8, 32'h2f, word);
		host.scan(1'b0, 33, 32'h0, word);
		check("usercode", word, {ROW0[31:22], 10'h000, REV});
		check("tdo driven", 32'(host.drove), 32'h1);
		tick(10);
		check("debug oe", 32'(debug_pin_oe_n), 32'h1);
		breakpoint_hit = 1'b1;
		tick(10);
		check("debug oe", 32'(debug_pin_oe_n), 32'h0);
		check("debug out", 32'(debug_pin_out), 32'h0);
		breakpoint_hit = 1'b0;
		debug_pin_is_output = 1'b0;
		debug_pin_in = 1'b0;
		tick(10);
		check("debug mode", 32'(debug_mode), 32'h1);
		debug_pin_in = 1'b1;
		tick(10);
		check("debug mode", 32'(debug_mode), 32'h0);
		// Second boot with scan port and debug pin locked out
		rst_n_pin = 1'b0;
		tick(1);
		check("cpu_start", 32'(cpu_start), 32'h0);
		dut.otp_mem[0] = 32'h0000_4001;
		tick(5);
		n_wr = 0;
		rst_n_pin = 1'b1;
		wait_start();
		check("security", security_q, 32'h0000_4001);
		debug_pin_is_output = 1'b1;
		breakpoint_hit = 1'b1;
		tick(10);
		check("debug oe", 32'(debug_pin_oe_n), 32'h1);
		host.drove = 1'b0;
		host.reset_tap();
		host.scan(1'b0, 32, 32'h0, word);
		check("tdo driven", 32'(host.drove), 32'h0);
		final_report();
	end
endmodule : otp_jtag_debug_port_tb
`default_nettype wire
